// ### design/gpio_mux_pkg.sv
/*
 Constants and carrier types shared by the general purpose pin function mux.
 Assumes a single 50 MHz system clock and an active low power-on reset.
*/
package gpio_mux_pkg;

   localparam int PIN_COUNT = 7;
   localparam int SEL_WIDTH = 8;
   localparam int ERR_WIDTH = 32;

   // Function select codes, control group
   localparam logic [7:0] SEL_NONE = 8'h00;
   localparam logic [7:0] SEL_EXT_LOSS = 8'h10;
   localparam logic [7:0] SEL_ERR_CLEAR = 8'h20;
   localparam logic [7:0] SEL_STOP_A1 = 8'h44;
   localparam logic [7:0] SEL_STOP_A0 = 8'h45;
   localparam logic [7:0] SEL_STOP_B1 = 8'h46;
   localparam logic [7:0] SEL_STOP_B0 = 8'h47;
   localparam logic [7:0] SEL_OUT_EN0 = 8'h70;
   localparam logic [7:0] SEL_OUT_EN1 = 8'h72;

   // Function select codes, status group
   localparam logic [7:0] SEL_IRQ = 8'h80;
   localparam logic [7:0] SEL_NO_ACTIVITY = 8'h88;
   localparam logic [7:0] SEL_CYCLE_FAIL = 8'h89;
   localparam logic [7:0] SEL_FREQ_FAIL = 8'h8A;
   localparam logic [7:0] SEL_SOAK = 8'h8B;
   localparam logic [7:0] SEL_REF_FAIL = 8'h8C;
   localparam logic [7:0] SEL_NORMAL = 8'hA8;
   localparam logic [7:0] SEL_HOLDOVER = 8'hA9;
   localparam logic [7:0] SEL_OUT_OF_RANGE = 8'hAD;
   localparam logic [7:0] SEL_LOCK0 = 8'hAF;
   localparam logic [7:0] SEL_LOCK1 = 8'hB0;
   localparam logic [7:0] SEL_LOCK2 = 8'hB1;
   localparam logic [7:0] SEL_LOCK3 = 8'hB2;

   // Bit positions in the stop clock vector
   localparam int STOP_B0 = 0;
   localparam int STOP_B1 = 1;
   localparam int STOP_A0 = 2;
   localparam int STOP_A1 = 3;

   // Bit positions in the reference failure mask
   localparam int MASK_LOSS = 0;
   localparam int MASK_CYCLE = 1;
   localparam int MASK_FREQ = 2;
   localparam int MASK_SOAK = 3;

   // Strap pins and the two pulled enable pins
   localparam logic [6:0] STRAP_PINS = 7'h3B;
   localparam int PULL_DOWN_PIN = 2;
   localparam int PULL_UP_PIN = 6;
   localparam logic [6:0] PULL_DOWN_MAP = 7'h04;
   localparam logic [6:0] PULL_UP_MAP = 7'h40;

   // Timing
   localparam int CLK_HZ = 50000000;
   localparam int STRAP_HOLD_MS = 55;
   localparam int STRAP_HOLD_CYCLES = STRAP_HOLD_MS * (CLK_HZ / 1000);
   localparam int MS_TICK_CYCLES = CLK_HZ / 1000;
   localparam int LOCK0_THRESH_US = 36;
   localparam int LOCK1_THRESH_US = 1;
   localparam int LOCK2_THRESH_US = 10;
   localparam int LOCK3_THRESH_US = 10;
   localparam int LOCK0_WINDOW_S = 10;
   localparam int LOCK1_WINDOW_S = 1;
   localparam int LOCK2_WINDOW_S = 1;
   localparam int LOCK3_WINDOW_S = 10;
   localparam int LOCK0_THRESH_NS = LOCK0_THRESH_US * 1000;
   localparam int LOCK1_THRESH_NS = LOCK1_THRESH_US * 1000;
   localparam int LOCK2_THRESH_NS = LOCK2_THRESH_US * 1000;
   localparam int LOCK3_THRESH_NS = LOCK3_THRESH_US * 1000;
   localparam int LOCK0_WINDOW_MS = LOCK0_WINDOW_S * 1000;
   localparam int LOCK1_WINDOW_MS = LOCK1_WINDOW_S * 1000;
   localparam int LOCK2_WINDOW_MS = LOCK2_WINDOW_S * 1000;
   localparam int LOCK3_WINDOW_MS = LOCK3_WINDOW_S * 1000;
   localparam int WINDOW_WIDTH = 14;

   typedef enum logic [1:0] {
      DPLL_NORMAL = 2'b00,
      DPLL_HOLDOVER = 2'b01,
      DPLL_FREERUN = 2'b10
   } dpll_state_type;

   typedef enum logic [1:0] {
      STRAP_HOLD = 2'b00,
      STRAP_CAPTURE = 2'b01,
      STRAP_DONE = 2'b10
   } strap_state_type;

   typedef struct packed {
      logic irq;
      logic no_activity;
      logic cycle_fail;
      logic freq_fail;
      logic soak;
      logic out_of_range;
   } status_type;

   typedef struct packed {
      logic ext_loss;
      logic err_clear;
      logic [3:0] stop_clock;
      logic [1:0] out_enable;
   } control_type;

endpackage

// ### design/pin_sync.sv
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes inputs that may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 7
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pin_level,
   output logic [WIDTH-1:0] pin_synced
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         pin_synced <= '0;
      end else begin
         stage1 <= pin_level;
         pin_synced <= stage1;
      end
   end

endmodule

// ### design/lock_monitor.sv
/*
 Lock qualifier: flags lock once the phase error has stayed under a
 threshold for a whole observation window counted in millisecond ticks.
 Assumes a one-cycle ms_tick enable and a registered phase error magnitude.
*/
`timescale 1ns/1ps
module lock_monitor #(
   parameter logic [31:0] THRESH_NS = 32'h000003E8,
   parameter logic [13:0] WINDOW_MS = 14'h03E8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ms_tick,
   input wire logic [31:0] phase_err_ns,
   output logic locked
);

   logic [13:0] quiet_ms;
   logic under;

   assign under = phase_err_ns < THRESH_NS;

   // Any excursion restarts the window and drops lock at once
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         quiet_ms <= '0;
      end else if (!under) begin
         quiet_ms <= '0;
      end else if (ms_tick && quiet_ms != WINDOW_MS) begin
         quiet_ms <= quiet_ms + 14'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         locked <= 1'b0;
      end else begin
         locked <= under && quiet_ms == WINDOW_MS;
      end
   end

endmodule

// ### design/gpio_function_mux.sv
/*
 Per-pin function mux for the seven general purpose pins: control
 inputs OR-ed into internal bits, status signals driven out, straps
 caught after reset, and the four lock qualifiers.
 Assumes pin inputs arrive asynchronously and select values are held in
 registers elsewhere; monitors and the DPLL supply the status levels.
*/
`timescale 1ns/1ps

// Overview of operation
// - each pin has an 8-bit function select, bits 7 to 0.
// - select 0x00 leaves the pin an input with no effect.
// - select 0x10 makes the pin an external reference loss flag.
// - select 0x20 ORs the pin into the phase error clear enable.
// - selects 0x44 to 0x47 OR the pin into post divider stop bits.
// - selects 0x70 and 0x72 OR the pin into output enables 0 and 1.
// - select 0x80 drives the pin with the device interrupt.
// - interrupt flags status change; host then reads the service registers.
// - select 0x88 drives high if reference had no activity last second.
// - selects 0x89 and 0x8A drive single-cycle and coarse-frequency failures.
// - select 0x8B drives the guard soak timer indicator.
// - select 0x8C drives the OR of unmasked reference failure indicators.
// - select 0xA8 drives high while the DPLL is in normal state.
// - select 0xA9 drives high while the DPLL is in holdover.
// - select 0xAD drives high while DPLL is beyond pull-in range.
// - select 0xAF drives lock 0: error under 36 us for 10 s.
// - select 0xB0 drives lock 1: error under 1 us for 1 s.
// - select 0xB1 drives lock 2: error under 10 us for 1 s.
// - select 0xB2 drives lock 3: error under 10 us for 10 s.
// - pins 0,1,3,4,5 are straps held 55 ms after reset release.
// - until straps settle, pin 2 pulled down leaves clock 0 to its register bit; pin 6 pulled up enables clock 1.
module gpio_function_mux #(
   parameter int STRAP_HOLD_CYCLES = gpio_mux_pkg::STRAP_HOLD_CYCLES,
   parameter int MS_TICK_CYCLES = gpio_mux_pkg::MS_TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [gpio_mux_pkg::PIN_COUNT*gpio_mux_pkg::SEL_WIDTH-1:0] pin_select,
   input wire logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_in,
   output logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_out,
   output logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_oe,
   output logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_pull_up,
   output logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_pull_down,
   input wire gpio_mux_pkg::control_type control_reg,
   input wire gpio_mux_pkg::status_type status,
   input wire logic [3:0] ref_fail_mask,
   input wire gpio_mux_pkg::dpll_state_type dpll_state,
   input wire logic [gpio_mux_pkg::ERR_WIDTH-1:0] phase_err_ns,
   output gpio_mux_pkg::control_type control_eff,
   output logic loss_of_signal_flag,
   output logic ref_fail,
   output logic [3:0] lock_ind,
   output logic [gpio_mux_pkg::PIN_COUNT-1:0] strap_value,
   output logic strap_done
);

   localparam logic [21:0] STRAP_LAST = 22'(STRAP_HOLD_CYCLES - 1);
   localparam logic [15:0] TICK_LAST = 16'(MS_TICK_CYCLES - 1);

   logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_synced;
   logic [21:0] strap_count;
   gpio_mux_pkg::strap_state_type strap_state;
   logic [15:0] tick_count;
   logic ms_tick;
   gpio_mux_pkg::control_type next_control;
   logic next_loss;
   logic next_ref_fail;
   logic [gpio_mux_pkg::PIN_COUNT-1:0] next_out;
   logic [gpio_mux_pkg::PIN_COUNT-1:0] next_oe;

   // Status select decode; unknown codes fall back to an undriven input
   function automatic logic [1:0] status_drive(
      input logic [7:0] sel,
      input gpio_mux_pkg::status_type st,
      input gpio_mux_pkg::dpll_state_type ds,
      input logic fail,
      input logic [3:0] lock
   );
      logic [1:0] r;
      r = 2'b00;
      case (sel)
         gpio_mux_pkg::SEL_IRQ: r = {1'b1, st.irq};
         gpio_mux_pkg::SEL_NO_ACTIVITY: r = {1'b1, st.no_activity};
         gpio_mux_pkg::SEL_CYCLE_FAIL: r = {1'b1, st.cycle_fail};
         gpio_mux_pkg::SEL_FREQ_FAIL: r = {1'b1, st.freq_fail};
         gpio_mux_pkg::SEL_SOAK: r = {1'b1, st.soak};
         gpio_mux_pkg::SEL_REF_FAIL: r = {1'b1, fail};
         gpio_mux_pkg::SEL_NORMAL: r = {1'b1, ds == gpio_mux_pkg::DPLL_NORMAL};
         gpio_mux_pkg::SEL_HOLDOVER: r = {1'b1, ds == gpio_mux_pkg::DPLL_HOLDOVER};
         gpio_mux_pkg::SEL_OUT_OF_RANGE: r = {1'b1, st.out_of_range};
         gpio_mux_pkg::SEL_LOCK0: r = {1'b1, lock[0]};
         gpio_mux_pkg::SEL_LOCK1: r = {1'b1, lock[1]};
         gpio_mux_pkg::SEL_LOCK2: r = {1'b1, lock[2]};
         gpio_mux_pkg::SEL_LOCK3: r = {1'b1, lock[3]};
         default: r = 2'b00;
      endcase
      return r;
   endfunction

   pin_sync #(
      .WIDTH(gpio_mux_pkg::PIN_COUNT)
   ) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .pin_level(pin_in),
      .pin_synced(pin_synced)
   );

   // Millisecond enable for the lock windows
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tick_count <= '0;
         ms_tick <= 1'b0;
      end else if (tick_count == TICK_LAST) begin
         tick_count <= '0;
         ms_tick <= 1'b1;
      end else begin
         tick_count <= tick_count + 16'h0001;
         ms_tick <= 1'b0;
      end
   end

   lock_monitor #(
      .THRESH_NS(32'(gpio_mux_pkg::LOCK0_THRESH_NS)),
      .WINDOW_MS(14'(gpio_mux_pkg::LOCK0_WINDOW_MS))
   ) u_lock0 (
      .core_clk(core_clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .phase_err_ns(phase_err_ns),
      .locked(lock_ind[0])
   );

   lock_monitor #(
      .THRESH_NS(32'(gpio_mux_pkg::LOCK1_THRESH_NS)),
      .WINDOW_MS(14'(gpio_mux_pkg::LOCK1_WINDOW_MS))
   ) u_lock1 (
      .core_clk(core_clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .phase_err_ns(phase_err_ns),
      .locked(lock_ind[1])
   );

   lock_monitor #(
      .THRESH_NS(32'(gpio_mux_pkg::LOCK2_THRESH_NS)),
      .WINDOW_MS(14'(gpio_mux_pkg::LOCK2_WINDOW_MS))
   ) u_lock2 (
      .core_clk(core_clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .phase_err_ns(phase_err_ns),
      .locked(lock_ind[2])
   );

   lock_monitor #(
      .THRESH_NS(32'(gpio_mux_pkg::LOCK3_THRESH_NS)),
      .WINDOW_MS(14'(gpio_mux_pkg::LOCK3_WINDOW_MS))
   ) u_lock3 (
      .core_clk(core_clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .phase_err_ns(phase_err_ns),
      .locked(lock_ind[3])
   );

   // Fixed pad pulls on the two enable pins
   assign pin_pull_up = gpio_mux_pkg::PULL_UP_MAP;
   assign pin_pull_down = gpio_mux_pkg::PULL_DOWN_MAP;

   // Strap hold: pins stay inputs until the hold time has run out
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         strap_state <= gpio_mux_pkg::STRAP_HOLD;
         strap_count <= '0;
      end else begin
         case (strap_state)
            gpio_mux_pkg::STRAP_HOLD: begin
               if (strap_count == STRAP_LAST) begin
                  strap_state <= gpio_mux_pkg::STRAP_CAPTURE;
               end else begin
                  strap_count <= strap_count + 22'h000001;
               end
            end
            gpio_mux_pkg::STRAP_CAPTURE: begin
               strap_state <= gpio_mux_pkg::STRAP_DONE;
            end
            default: begin
               strap_state <= gpio_mux_pkg::STRAP_DONE;
            end
         endcase
      end
   end

   // Straps caught from the synchronised levels, never at reset itself
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         strap_value <= '0;
      end else if (strap_state == gpio_mux_pkg::STRAP_CAPTURE) begin
         strap_value <= pin_synced & gpio_mux_pkg::STRAP_PINS;
      end
   end

   assign strap_done = strap_state == gpio_mux_pkg::STRAP_DONE;

   // Control path: synchronised pin levels OR-ed into register bits
   always_comb begin
      next_control = control_reg;
      next_loss = 1'b0;
      for (int i = 0; i < gpio_mux_pkg::PIN_COUNT; i++) begin
         if (strap_done) begin
            case (pin_select[i*8 +: 8])
               gpio_mux_pkg::SEL_EXT_LOSS: next_loss = next_loss | pin_synced[i];
               gpio_mux_pkg::SEL_ERR_CLEAR: begin
                  next_control.err_clear = next_control.err_clear | pin_synced[i];
               end
               gpio_mux_pkg::SEL_STOP_A1: begin
                  next_control.stop_clock[gpio_mux_pkg::STOP_A1] =
                     next_control.stop_clock[gpio_mux_pkg::STOP_A1] | pin_synced[i];
               end
               gpio_mux_pkg::SEL_STOP_A0: begin
                  next_control.stop_clock[gpio_mux_pkg::STOP_A0] =
                     next_control.stop_clock[gpio_mux_pkg::STOP_A0] | pin_synced[i];
               end
               gpio_mux_pkg::SEL_STOP_B1: begin
                  next_control.stop_clock[gpio_mux_pkg::STOP_B1] =
                     next_control.stop_clock[gpio_mux_pkg::STOP_B1] | pin_synced[i];
               end
               gpio_mux_pkg::SEL_STOP_B0: begin
                  next_control.stop_clock[gpio_mux_pkg::STOP_B0] =
                     next_control.stop_clock[gpio_mux_pkg::STOP_B0] | pin_synced[i];
               end
               gpio_mux_pkg::SEL_OUT_EN0: begin
                  next_control.out_enable[0] = next_control.out_enable[0] | pin_synced[i];
               end
               gpio_mux_pkg::SEL_OUT_EN1: begin
                  next_control.out_enable[1] = next_control.out_enable[1] | pin_synced[i];
               end
               default: begin
               end
            endcase
         end
      end
      // Before straps settle, only the pulled pins are OR-ed into the register bits of the two enables
      if (!strap_done) begin
         next_control.out_enable[0] = control_reg.out_enable[0] |
            pin_synced[gpio_mux_pkg::PULL_DOWN_PIN];
         next_control.out_enable[1] = control_reg.out_enable[1] |
            pin_synced[gpio_mux_pkg::PULL_UP_PIN];
      end
      next_control.ext_loss = control_reg.ext_loss | next_loss;
   end

   assign next_ref_fail =
      (next_control.ext_loss & ref_fail_mask[gpio_mux_pkg::MASK_LOSS]) |
      (status.cycle_fail & ref_fail_mask[gpio_mux_pkg::MASK_CYCLE]) |
      (status.freq_fail & ref_fail_mask[gpio_mux_pkg::MASK_FREQ]) |
      (status.soak & ref_fail_mask[gpio_mux_pkg::MASK_SOAK]);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         control_eff <= '0;
         loss_of_signal_flag <= 1'b0;
         ref_fail <= 1'b0;
      end else begin
         control_eff <= next_control;
         loss_of_signal_flag <= next_control.ext_loss;
         ref_fail <= next_ref_fail;
      end
   end

   // Status path: one select byte per pin picks the driven level
   always_comb begin
      logic [1:0] drive;
      drive = 2'b00;
      next_out = '0;
      next_oe = '0;
      for (int i = 0; i < gpio_mux_pkg::PIN_COUNT; i++) begin
         drive = status_drive(pin_select[i*8 +: 8], status, dpll_state, ref_fail,
            lock_ind);
         // No pin may drive while a strap could still be sampled
         next_oe[i] = drive[1] & strap_done;
         next_out[i] = drive[0] & strap_done;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
      end
   end

endmodule

// ### sim/gpio_mux_asserts.sv
/*
 Concurrent checks on the ports of the pin function mux, bound to it.
 Assumes one clock domain and the pin roles driven by the bench.
*/
`timescale 1ns/1ps
module gpio_mux_asserts #(
   parameter int STRAP_HOLD_CYCLES = 50,
   parameter int MS_TICK_CYCLES = 4
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [55:0] pin_select,
   input wire logic [6:0] pin_in,
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe,
   input wire logic [6:0] pin_pull_up,
   input wire logic [6:0] pin_pull_down,
   input wire gpio_mux_pkg::control_type control_reg,
   input wire gpio_mux_pkg::status_type status,
   input wire logic [3:0] ref_fail_mask,
   input wire gpio_mux_pkg::dpll_state_type dpll_state,
   input wire logic [31:0] phase_err_ns,
   input wire gpio_mux_pkg::control_type control_eff,
   input wire logic loss_of_signal_flag,
   input wire logic ref_fail,
   input wire logic [3:0] lock_ind,
   input wire logic [6:0] strap_value,
   input wire logic strap_done
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_hold_undriven:
      assert property (!strap_done |-> pin_oe == 7'h00) else $error("pin driven in strap hold");
   a_pulls_fixed:
      assert property (pin_pull_up == 7'h40 && pin_pull_down == 7'h04) else $error("pulls wrong");
   a_none_input:
      assert property (pin_select[7:0] == 8'h00 |=> !pin_oe[0]) else $error("idle pin driven");
   a_ctrl_input:
      assert property (pin_select[15:8] < 8'h80 |=> !pin_oe[1]) else $error("control pin driven");
   a_spare_input:
      assert property (pin_select[23:16] == 8'h81 |=> !pin_oe[2]) else $error("spare pin driven");
   a_irq_pin:
      assert property (strap_done && $past(strap_done) && pin_select[7:0] == 8'h80
         |=> pin_oe[0] && pin_out[0] == $past(status.irq)) else $error("irq pin wrong");
   a_normal_pin:
      assert property (strap_done && $past(strap_done) && pin_select[15:8] == 8'hA8
         |=> pin_out[1] == ($past(dpll_state) == gpio_mux_pkg::DPLL_NORMAL))
         else $error("normal pin wrong");
   a_clear_path:
      assert property ((strap_done && pin_select[15:8] == 8'h20 && pin_in[1])[*3]
         |=> control_eff.err_clear) else $error("clear enable not set");
   a_loss_path:
      assert property ((strap_done && pin_select[7:0] == 8'h10 && pin_in[0])[*3]
         |=> loss_of_signal_flag) else $error("loss flag not set");
   a_fail_comb:
      assert property ((status.cycle_fail && ref_fail_mask[1])[*2] |=> ref_fail)
         else $error("reference failure missed");
   a_lock0_drop:
      assert property ((phase_err_ns >= gpio_mux_pkg::LOCK0_THRESH_NS)[*2] |=> !lock_ind[0])
         else $error("lock 0 held");
   a_lock1_drop:
      assert property ((phase_err_ns >= gpio_mux_pkg::LOCK1_THRESH_NS)[*2] |=> !lock_ind[1])
         else $error("lock 1 held");
   a_lock2_drop:
      assert property ((phase_err_ns >= gpio_mux_pkg::LOCK2_THRESH_NS)[*2] |=> !lock_ind[2])
         else $error("lock 2 held");
   a_lock3_drop:
      assert property ((phase_err_ns >= gpio_mux_pkg::LOCK3_THRESH_NS)[*2] |=> !lock_ind[3])
         else $error("lock 3 held");
endmodule

bind gpio_function_mux gpio_mux_asserts #(
   .STRAP_HOLD_CYCLES(STRAP_HOLD_CYCLES),
   .MS_TICK_CYCLES(MS_TICK_CYCLES)
) gpio_mux_asserts_i (.core_clk, .nrst, .pin_select, .pin_in, .pin_out, .pin_oe,
   .pin_pull_up, .pin_pull_down, .control_reg, .status, .ref_fail_mask, .dpll_state,
   .phase_err_ns, .control_eff, .loss_of_signal_flag, .ref_fail, .lock_ind,
   .strap_value, .strap_done);

// ### sim/pin_board.sv
/*
 Board side of the seven pins: straps, pulls and released lines.
 Assumes the bench says which pins the board drives and to what level.
*/
`timescale 1ns/1ps
module pin_board (
   input wire logic core_clk,
   input wire logic [6:0] drive_en,
   input wire logic [6:0] drive_val,
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe,
   input wire logic [6:0] pin_pull_up,
   input wire logic [6:0] pin_pull_down,
   output logic [6:0] pin_in
);
   logic flip = 1'b0;
   // Floating pins wander, so a stale level never passes for a driven one
   always_ff @(posedge core_clk) begin
      flip <= ~flip;
   end
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (drive_en[i]) begin
            pin_in[i] = drive_val[i];
         end else if (pin_pull_up[i] || pin_pull_down[i]) begin
            pin_in[i] = pin_pull_up[i];
         end else begin
            pin_in[i] = flip ^ i[0];
         end
      end
   end
endmodule

// ### sim/tb.sv
/*
 Self-checking bench for the pin function mux: straps, control and
 status selects, lock qualifiers and a second reset.
 Assumes short strap and tick counts set through the top parameters.
*/
`timescale 1ns/1ps
`define CMP(nm, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected %s expected %h seen %h", nm, e, a); end end
module tb;
   localparam int HOLD = 50;
   localparam int TICK = 4;
   typedef struct {int w; logic [7:0] e;} note_type;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [55:0] pin_select = '0;
   logic [6:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, strap_value, straps;
   gpio_mux_pkg::control_type control_reg = '0;
   gpio_mux_pkg::control_type control_eff;
   gpio_mux_pkg::status_type status = '0;
   logic [3:0] ref_fail_mask = '0;
   gpio_mux_pkg::dpll_state_type dpll_state = gpio_mux_pkg::DPLL_FREERUN;
   logic [31:0] phase_err_ns = 32'h00009C40;
   logic [3:0] lock_ind;
   logic loss_of_signal_flag, ref_fail, strap_done;
   logic [6:0] drive_en = '0;
   logic [6:0] drive_val = '0;
   note_type notes[$];
   event look;
   int checks = 0;
   int miscompares = 0;
   string nm[10] = '{"pin_out", "pin_oe", "control_eff", "loss_of_signal_flag", "ref_fail",
      "lock_ind", "strap_value", "strap_done", "pin_pull_up", "pin_pull_down"};

   gpio_function_mux #(.STRAP_HOLD_CYCLES(HOLD), .MS_TICK_CYCLES(TICK)) gpio_function_mux_i (
      .core_clk, .nrst, .pin_select, .pin_in, .pin_out, .pin_oe, .pin_pull_up,
      .pin_pull_down, .control_reg, .status, .ref_fail_mask, .dpll_state, .phase_err_ns,
      .control_eff, .loss_of_signal_flag, .ref_fail, .lock_ind, .strap_value, .strap_done);
   pin_board pin_board_i (.core_clk, .drive_en, .drive_val, .pin_out, .pin_oe,
      .pin_pull_up, .pin_pull_down, .pin_in);

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   function automatic logic [7:0] seen(int w);
      case (w)
         0: return {1'b0, pin_out};
         1: return {1'b0, pin_oe};
         2: return control_eff;
         3: return {7'h00, loss_of_signal_flag};
         4: return {7'h00, ref_fail};
         5: return {4'h0, lock_ind};
         6: return {1'b0, strap_value};
         7: return {7'h00, strap_done};
         8: return {1'b0, pin_pull_up};
         default: return {1'b0, pin_pull_down};
      endcase
   endfunction

   task note(int w, logic [7:0] e);
      notes.push_back('{w, e});
      -> look;
   endtask

   task tick(int n);
      repeat (n) @(negedge core_clk);
   endtask

   initial begin
      note_type n;
      forever begin
         @(look);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            `CMP(nm[n.w], n.e, seen(n.w))
         end
      end
   end

   task give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task do_reset();
      int k;
      nrst = 1'b0;
      straps = 7'($urandom());
      drive_en = 7'h3B;
      drive_val = straps;
      control_reg = '0;
      tick(3);
      note(1, 8'h00);
      note(7, 8'h00);
      note(8, 8'h40);
      note(9, 8'h04);
      nrst = 1'b1;
      tick(10);
      note(2, 8'h02);
      note(1, 8'h00);
      k = 0;
      while (strap_done !== 1'b1 && k < 200) begin
         tick(1);
         k++;
      end
      if (k == 200) begin
         miscompares++;
         give_verdict();
      end
      note(6, {1'b0, straps & 7'h3B});
      note(7, 8'h01);
      drive_en = '0;
      $display("test reset and straps done");
   endtask

   task control_test();
      logic [7:0] codes[10] = '{8'h10, 8'h20, 8'h44, 8'h45, 8'h46, 8'h47, 8'h70, 8'h72,
         8'h00, 8'h33};
      logic [7:0] bits[10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02,
         8'h00, 8'h00};
      int p;
      for (int i = 0; i < 10; i++) begin
         p = i % 7;
         pin_select = '0;
         pin_select[8*p +: 8] = codes[i];
         control_reg = gpio_mux_pkg::control_type'(8'($urandom()));
         drive_en = 7'(1 << p);
         drive_val = drive_en;
         tick(4);
         note(2, control_reg | bits[i]);
         note(3, {7'h00, control_reg.ext_loss | (codes[i] == 8'h10)});
         note(1, 8'h00);
         drive_val = '0;
         tick(4);
         note(2, control_reg);
      end
      drive_en = '0;
      $display("test control selects done");
   endtask

   task status_test();
      logic [7:0] tbl[15] = '{8'h80, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'hA8, 8'hA9, 8'hAD,
         8'hAF, 8'hB0, 8'hB1, 8'hB2, 8'h81, 8'h20};
      logic [6:0] eo, ev;
      logic [7:0] c;
      logic f;
      for (int t = 0; t < 15; t++) begin
         status = gpio_mux_pkg::status_type'(6'($urandom()));
         dpll_state = gpio_mux_pkg::dpll_state_type'(2'($urandom_range(0, 2)));
         ref_fail_mask = 4'($urandom());
         control_reg = gpio_mux_pkg::control_type'(8'($urandom()));
         f = (control_reg.ext_loss & ref_fail_mask[0]) | (status.cycle_fail & ref_fail_mask[1])
            | (status.freq_fail & ref_fail_mask[2]) | (status.soak & ref_fail_mask[3]);
         for (int i = 0; i < 7; i++) begin
            c = tbl[(i + t) % 15];
            pin_select[8*i +: 8] = c;
            eo[i] = (c != 8'h81 && c != 8'h20);
            case (c)
               8'h80: ev[i] = status.irq;
               8'h88: ev[i] = status.no_activity;
               8'h89: ev[i] = status.cycle_fail;
               8'h8A: ev[i] = status.freq_fail;
               8'h8B: ev[i] = status.soak;
               8'h8C: ev[i] = f;
               8'hA8: ev[i] = dpll_state == gpio_mux_pkg::DPLL_NORMAL;
               8'hA9: ev[i] = dpll_state == gpio_mux_pkg::DPLL_HOLDOVER;
               8'hAD: ev[i] = status.out_of_range;
               default: ev[i] = 1'b0;
            endcase
         end
         tick(3);
         note(0, {1'b0, ev});
         note(1, {1'b0, eo});
         note(4, {7'h00, f});
      end
      $display("test status selects done");
   endtask

   task lock_test();
      int w;
      w = 1000 * TICK;
      pin_select = {24'h000000, 8'hB2, 8'hB1, 8'hB0, 8'hAF};
      // Just under the tightest threshold, so every qualifier may count
      phase_err_ns = 32'h000003E7;
      tick(w - 20);
      note(5, 8'h00);
      tick(60);
      note(5, 8'h06);
      note(0, 8'h06);
      tick(9 * w);
      note(5, 8'h0F);
      note(0, 8'h0F);
      // Exactly at the 10 us threshold counts as an excursion
      phase_err_ns = 32'h00002710;
      tick(4);
      note(5, 8'h01);
      $display("test lock qualifiers done");
   endtask

   initial begin
      void'($urandom(56));
      do_reset();
      control_test();
      status_test();
      do_reset();
      lock_test();
      tick(2);
      give_verdict();
   end
endmodule
